//--- shared/isdc_pkg.sv
// Package with constants and carrier types for the interleaved static column DRAM controller
package isdc_pkg;
  localparam int ROW_W         = 10;
  localparam int COL_W         = 10;
  localparam int BANK_ADDR_W   = ROW_W + COL_W;
  localparam int WORD_ADDR_W   = BANK_ADDR_W + 1;
  localparam int DATA_W        = 32;
  localparam int BANK_DEPTH    = 1 << BANK_ADDR_W;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RAS_FAST_NS   = 85;
  localparam int RAS_SLOW_NS   = 100;
  localparam int FAST_INIT_CYC = 4;
  localparam int SLOW_INIT_CYC = 5;
  localparam int BURST_CYC     = 2;
  localparam int PRECHARGE_CYC = 1;
  localparam int DECODE_CYC    = 1;
  // Wait count after the row strobe cycle; the decode, row and final ready cycles are not counted
  localparam logic [2:0] FAST_WAIT = 3'(FAST_INIT_CYC - DECODE_CYC - 2);
  localparam logic [2:0] SLOW_WAIT = 3'(SLOW_INIT_CYC - DECODE_CYC - 2);
  localparam logic [2:0] REFRESH_CYC = 3'h4;

  typedef enum logic [2:0] {
    ISDC_IDLE    = 3'b000,
    ISDC_RAS     = 3'b001,
    ISDC_WAIT    = 3'b010,
    ISDC_BURST   = 3'b011,
    ISDC_REFRESH = 3'b100
  } isdc_state_t;

  typedef struct packed {
    logic                   req;
    logic                   burst;
    logic                   write;
    logic [WORD_ADDR_W-1:0] addr;
  } isdc_req_t;

  typedef struct packed {
    logic              rdy;
    logic              burst_ack;
    logic [DATA_W-1:0] data;
  } isdc_rsp_t;
endpackage

//--- hw/isdc_ctrl.sv
// Interleaved static column DRAM instruction memory controller
// Summary of operation
// - Non-sequential access: one decode cycle plus three fetch cycles, four total.
// - Slow DRAM option stretches initial access to five cycles.
// - Each bank completes a burst word in two cycles.
// - Banks overlap so each later burst word arrives every cycle.
// - Two banks, even and odd words, each 1M by 32 bits.
// - Read-only instruction port plus read/write data port.
// - Data-memory variant keeps only the read/write data port.
// - Data-bus output buffers off while fetching instructions.
// - Chip select is registered and qualifies writes.
// - Write data reaches memory through input latches.
// - No open-row compare; every new access precharges and reopens a row.
// - Sequential words change only column address, no column strobe.
// - Refresh wins over pending accesses when leaving idle.
// - Burst requests and bus invalid pass a capture register first.
// - Idle state acts as precharge between sequences.
`timescale 1ns/100ps
`default_nettype none
module isdc_ctrl
  import isdc_pkg::*;
#(
  parameter bit INSTR_PORT = 1'b1,
  parameter bit SLOW_DRAM  = 1'b0
) (
  input  wire logic  sys_clk,
  input  wire logic  nrst,
  input  wire isdc_req_t instr_req,
  input  wire logic  instr_burst_request,
  input  wire isdc_req_t data_req,
  input  wire logic  data_burst_request,
  input  wire logic  [DATA_W-1:0] data_wdata,
  input  wire logic  bus_invalid,
  input  wire logic  refresh_request,
  output isdc_rsp_t  instr_rsp,
  output isdc_rsp_t  data_rsp,
  output logic       data_oe_n,
  output logic       instr_oe_n,
  output logic       ras_n,
  output logic       chip_select_n,
  output logic       refresh_done
);
  // The 3-bit wait counter needs at least the decode, row and final ready cycles, and at most 10 in total
  if (FAST_INIT_CYC < 3 || SLOW_INIT_CYC < FAST_INIT_CYC || SLOW_INIT_CYC > 10) begin : g_bad_timing
    $error("initial access counts out of range");
  end

  logic [DATA_W-1:0] mem_even [BANK_DEPTH];
  logic [DATA_W-1:0] mem_odd  [BANK_DEPTH];

  isdc_state_t state;
  isdc_state_t next_state;
  logic       instr_burst_request_d;
  logic       data_burst_request_d;
  logic       bus_invalid_d;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic       is_data;
  logic       is_write;
  logic [WORD_ADDR_W-1:0] waddr;
  logic [DATA_W-1:0] wlatch;
  logic [DATA_W-1:0] rdata;

  // Capture register for late bus controls
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      instr_burst_request_d <= 1'b0;
      data_burst_request_d <= 1'b0;
      bus_invalid_d  <= 1'b0;
    end else begin
      instr_burst_request_d <= instr_burst_request;
      data_burst_request_d <= data_burst_request;
      bus_invalid_d  <= bus_invalid;
    end
  end

  wire         i_start = INSTR_PORT && instr_req.req && !bus_invalid_d;
  wire         d_start = data_req.req && !bus_invalid_d;
  wire   [2:0] init_wait = SLOW_DRAM ? SLOW_WAIT : FAST_WAIT;
  wire         burst_on = is_data ? data_burst_request_d : instr_burst_request_d;
  wire         word_rdy = (state == ISDC_WAIT && cnt == 3'h0)
                        || (state == ISDC_BURST && burst_on);
  wire         bank_odd = waddr[0];
  wire [BANK_ADDR_W-1:0] bank_addr = waddr[WORD_ADDR_W-1:1];
  // Read one word ahead so the next burst word stands when its ready is shown
  wire [WORD_ADDR_W-1:0] step_addr = waddr + WORD_ADDR_W'(1);
  wire [WORD_ADDR_W-1:0] rd_addr   = word_rdy ? step_addr : waddr;
  wire [BANK_ADDR_W-1:0] rd_bank   = rd_addr[WORD_ADDR_W-1:1];

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ISDC_IDLE: begin
        if (refresh_request) begin
          next_state = ISDC_REFRESH;
          next_cnt   = REFRESH_CYC;
        end else if (d_start || i_start) begin
          next_state = ISDC_RAS;
        end
      end
      ISDC_RAS: begin
        next_state = ISDC_WAIT;
        next_cnt   = init_wait;
      end
      ISDC_WAIT: begin
        if (cnt == 3'h0) begin
          next_state = burst_on ? ISDC_BURST : ISDC_IDLE;
        end else begin
          next_cnt = cnt - 3'h1;
        end
      end
      ISDC_BURST: begin
        if (!burst_on || bus_invalid_d || (!is_data && d_start)) begin
          next_state = ISDC_IDLE;
        end
      end
      ISDC_REFRESH: begin
        if (cnt == 3'h0) begin
          next_state = ISDC_IDLE;
        end else begin
          next_cnt = cnt - 3'h1;
        end
      end
      default: next_state = ISDC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ISDC_IDLE;
      cnt   <= 3'h0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Access latch: address, direction and write data
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      is_data  <= 1'b0;
      is_write <= 1'b0;
      waddr    <= '0;
      wlatch   <= '0;
    end else begin
      if (state == ISDC_IDLE && next_state == ISDC_RAS) begin
        is_data  <= d_start;
        is_write <= d_start ? data_req.write : 1'b0;
        waddr    <= d_start ? data_req.addr : instr_req.addr;
      end else if (word_rdy) begin
        waddr <= step_addr;
      end
      wlatch <= data_wdata;
    end
  end

  // Registered strobes and bank array access
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ras_n         <= 1'b1;
      chip_select_n <= 1'b1;
      refresh_done  <= 1'b0;
      rdata         <= '0;
    end else begin
      ras_n         <= !(next_state inside {ISDC_RAS, ISDC_WAIT, ISDC_BURST, ISDC_REFRESH});
      chip_select_n <= !(next_state inside {ISDC_WAIT, ISDC_BURST});
      // Done shows in the last refresh cycle so the request drops before idle
      refresh_done  <= (state == ISDC_REFRESH) && (cnt == 3'h1);
      rdata         <= rd_addr[0] ? mem_odd[rd_bank] : mem_even[rd_bank];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (word_rdy && is_write && !chip_select_n) begin
      if (bank_odd) begin
        mem_odd[bank_addr] <= wlatch;
      end else begin
        mem_even[bank_addr] <= wlatch;
      end
    end
  end

  wire ack    = state inside {ISDC_RAS, ISDC_WAIT, ISDC_BURST};

  assign instr_rsp.rdy       = word_rdy && !is_data;
  assign instr_rsp.burst_ack = ack && !is_data;
  assign instr_rsp.data      = rdata;
  assign data_rsp.rdy        = word_rdy && is_data;
  assign data_rsp.burst_ack  = ack && is_data;
  assign data_rsp.data       = rdata;
  assign data_oe_n  = !(word_rdy && is_data && !is_write);
  assign instr_oe_n = !(word_rdy && !is_data);

  property p_data_oe_off;
    @(posedge sys_clk) disable iff (!nrst) (!is_data) |-> data_oe_n;
  endproperty
  a_data_oe_off: assert property (p_data_oe_off) else $error("data buffers on during fetch");

  property p_init_len;
    @(posedge sys_clk) disable iff (!nrst)
      (state == ISDC_IDLE && next_state == ISDC_RAS && !SLOW_DRAM) |-> ##3 word_rdy;
  endproperty
  a_init_len: assert property (p_init_len) else $error("first word not on fourth cycle");

  property p_refresh_first;
    @(posedge sys_clk) disable iff (!nrst)
      (state == ISDC_IDLE && refresh_request) |=> state == ISDC_REFRESH;
  endproperty
  a_refresh_first: assert property (p_refresh_first) else $error("refresh lost priority");

  property p_idle_precharge;
    @(posedge sys_clk) disable iff (!nrst)
      (state == ISDC_IDLE) |-> ras_n;
  endproperty
  a_idle_precharge: assert property (p_idle_precharge) else $error("no precharge");

  property p_open_row;
    @(posedge sys_clk) disable iff (!nrst)
      (state == ISDC_BURST) |-> !ras_n && !chip_select_n;
  endproperty
  a_open_row: assert property (p_open_row) else $error("row closed during burst");

  property p_cs_reg;
    @(posedge sys_clk) disable iff (!nrst)
      (state == ISDC_IDLE) |=> chip_select_n;
  endproperty
  a_cs_reg: assert property (p_cs_reg) else $error("chip select in idle");

  property p_capture;
    @(posedge sys_clk) disable iff (!nrst)
      (state == ISDC_BURST && is_data && !$past(data_burst_request)) |-> !data_rsp.rdy;
  endproperty
  a_capture: assert property (p_capture) else $error("request not captured");

  property p_new_row;
    @(posedge sys_clk) disable iff (!nrst)
      (state == ISDC_RAS) |-> $past(ras_n);
  endproperty
  a_new_row: assert property (p_new_row) else $error("row opened without precharge");
endmodule
`default_nettype wire

//--- test/isdc_cpu.sv
// Processor bus model for one port of the memory controller
`timescale 1ns/100ps
`default_nettype none
module isdc_cpu
  import isdc_pkg::*;
(
  input  wire isdc_rsp_t    rsp,
  input  wire logic         sys_clk,
  output isdc_req_t         req,
  output logic              burst_request,
  output logic [DATA_W-1:0] wdata
);
  logic [DATA_W-1:0] words [8];
  int                lat;
  int                gaps;
  initial begin
    req = '0;
    burst_request = 1'b0;
    wdata = '0;
  end
  // Holds the request until acknowledged, then collects n words
  task automatic xfer(input logic wr, input logic [WORD_ADDR_W-1:0] a, input int n,
                      input logic [DATA_W-1:0] wd);
    int cyc;
    int got;
    int last;
    logic acked;
    // Cycle 1 is the decode cycle in which the request is first presented
    cyc = 1;
    got = 0;
    gaps = 0;
    lat = -1;
    last = 0;
    acked = 1'b0;
    req.req = 1'b1;
    req.burst = n > 1;
    req.write = wr;
    req.addr = a;
    burst_request = n > 1;
    wdata = wd;
    while (got < n && cyc < 40) begin
      @(posedge sys_clk);
      #1;
      cyc++;
      if (acked) req.req = 1'b0;
      if (rsp.rdy === 1'b1) begin
        words[got] = rsp.data;
        if (got == 0) lat = cyc;
        else if (cyc - last > 1) gaps++;
        last = cyc;
        got++;
      end
      acked = acked || (rsp.burst_ack === 1'b1);
    end
    req = '0;
    burst_request = 1'b0;
    wdata = ~wd;
  endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking testbench for the memory controller
`timescale 1ns/100ps
`default_nettype none
module tb;
  import isdc_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic bus_invalid = 1'b0;
  logic refresh_want = 1'b0;
  logic refresh_seen = 1'b0;
  wire refresh_request = refresh_want && !refresh_seen;
  isdc_req_t ireq, dreq;
  isdc_rsp_t irsp, drsp;
  logic ibr, dbr, data_oe_n, instr_oe_n, ras_n, chip_select_n, refresh_done;
  logic [DATA_W-1:0] wd;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  isdc_cpu cpu_i (.rsp(irsp), .sys_clk(sys_clk), .req(ireq), .burst_request(ibr), .wdata());
  isdc_cpu cpu_d (.rsp(drsp), .sys_clk(sys_clk), .req(dreq), .burst_request(dbr), .wdata(wd));
  isdc_ctrl isdc_ctrl_i (.sys_clk(sys_clk), .nrst(nrst), .instr_req(ireq),
    .instr_burst_request(ibr), .data_req(dreq), .data_burst_request(dbr), .data_wdata(wd),
    .bus_invalid(bus_invalid), .refresh_request(refresh_request), .instr_rsp(irsp),
    .data_rsp(drsp), .data_oe_n(data_oe_n), .instr_oe_n(instr_oe_n), .ras_n(ras_n),
    .chip_select_n(chip_select_n), .refresh_done(refresh_done));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_sim();
    end
  end
  always @(posedge sys_clk) begin
    if (irsp.rdy === 1'b1) begin
      check(32'(data_oe_n), 32'h1);
      check(32'(instr_oe_n), 32'h0);
    end
    if (refresh_done === 1'b1) begin
      refresh_seen <= 1'b1;
    end
  end
  task automatic t_reset();
    check({27'h0, ras_n, chip_select_n, data_oe_n, instr_oe_n, drsp.rdy}, 32'h1E);
  endtask
  task automatic t_write_read();
    cpu_d.xfer(1'b1, 21'h00A10, 1, 32'hA5A5_0001);
    idle(4);
    cpu_d.xfer(1'b1, 21'h00A11, 1, 32'h5A5A_0002);
    idle(4);
    cpu_d.xfer(1'b0, 21'h00A10, 2, 32'h0);
    check(32'(cpu_d.lat), 32'(FAST_INIT_CYC));
    check(cpu_d.words[0], 32'hA5A5_0001);
    check(cpu_d.words[1], 32'h5A5A_0002);
    check(32'(cpu_d.gaps), 32'h0);
    idle(4);
  endtask
  task automatic t_instr();
    cpu_i.xfer(1'b0, 21'h00A11, 1, 32'h0);
    check(32'(cpu_i.lat), 32'(FAST_INIT_CYC));
    check(cpu_i.words[0], 32'h5A5A_0002);
    idle(4);
  endtask
  task automatic t_refresh();
    refresh_want = 1'b1;
    cpu_d.xfer(1'b0, 21'h00A10, 1, 32'h0);
    refresh_want = 1'b0;
    check(32'(refresh_seen), 32'h1);
    check(32'(cpu_d.lat > FAST_INIT_CYC), 32'h1);
    idle(4);
  endtask
  task automatic t_invalid();
    bus_invalid = 1'b1;
    idle(1);
    cpu_d.xfer(1'b0, 21'h00A10, 1, 32'h0);
    check(32'(cpu_d.lat), 32'hFFFF_FFFF);
    bus_invalid = 1'b0;
    idle(4);
  endtask
  initial begin
    idle(1);
    t_reset();
    idle(19);
    nrst = 1'b1;
    idle(1);
    t_write_read();
    t_instr();
    t_refresh();
    t_invalid();
    end_sim();
  end
endmodule
`default_nettype wire
